// ===== verilog/rscs_regs.svh
`ifndef RSCS_REGS_SVH
`define RSCS_REGS_SVH

// Strap pin layout
`define RSCS_NUM_GPIO        16
`define RSCS_PORT_SEL_PIN    9
`define RSCS_DEF_SEL_BITS    4
`define RSCS_NUM_OUT_CLK     12

// Reset values of the straps and of the register defaults
`define RSCS_GPIO_IDLE       16'hffff
`define RSCS_OUT_EN_RESET    12'h000
`define RSCS_GPIO_OE_RESET   16'h0000

// Synchroniser depth before the strap sample is taken
`define RSCS_CAPTURE_CYCLE   2'h2

// Timing: clock period and settle times in ns, counts derived
`define RSCS_CLK_PERIOD_NS   20
`define RSCS_REG_SETTLE_NS   2000
`define RSCS_CLK_SETTLE_NS   1000
`define RSCS_REG_SETTLE_CYC  ((`RSCS_REG_SETTLE_NS + `RSCS_CLK_PERIOD_NS - 1) / `RSCS_CLK_PERIOD_NS)
`define RSCS_CLK_SETTLE_CYC  ((`RSCS_CLK_SETTLE_NS + `RSCS_CLK_PERIOD_NS - 1) / `RSCS_CLK_PERIOD_NS)
`define RSCS_CNT_W           8

`endif

// ===== verilog/rscs_pkg.sv
`include "rscs_regs.svh"

package rscs_pkg;

   typedef struct packed {
      logic        main_i2c;
      logic        eeprom_off;
      logic        addr_bit;
      logic [15:0] sel_idx;
   } rscs_strap_t;

   typedef struct packed {
      logic [11:0] out_clk_en;
      logic [15:0] gpio_oe;
   } rscs_cfg_t;

   typedef enum logic [3:0] {
      ST_CAPTURE,
      ST_OTP,
      ST_OTP_WAIT,
      ST_EE,
      ST_EE_WAIT,
      ST_REG,
      ST_CLK,
      ST_CAL,
      ST_LOCK,
      ST_DONE
   } rscs_state_t;

endpackage

// ===== verilog/rscs_strap_decode.sv
`timescale 1ns/1ns
`include "rscs_regs.svh"

module rscs_strap_decode
   import rscs_pkg::*;
(
   input  wire logic [15:0] pins,
   input  wire logic        programmed,
   input  wire logic [15:0] sel_mask,
   input  wire logic [15:0] off_mask,
   input  wire logic [15:0] addr_mask,
   output rscs_strap_t      strap
);

   // Packs masked pins, lowest index into the LSB
   function automatic logic [15:0] pack_pins(input logic [15:0] p, input logic [15:0] m);
      logic [15:0] r;
      logic [4:0]  n;
      r = 16'h0000;
      n = 5'h00;
      for (int i = 0; i < `RSCS_NUM_GPIO; i++) begin
         if (m[i]) begin
            r[n[3:0]] = p[i];
            n = n + 5'h01;
         end
      end
      return r;
   endfunction

   // Level of the highest-indexed masked pin, zero if none
   function automatic logic top_pin(input logic [15:0] p, input logic [15:0] m);
      logic r;
      r = 1'b0;
      for (int i = 0; i < `RSCS_NUM_GPIO; i++) begin
         if (m[i]) begin
            r = p[i];
         end
      end
      return r;
   endfunction

   logic [15:0] eff_sel;
   logic [15:0] eff_off;
   logic [15:0] eff_addr;

   always_comb begin
      // Unprogrammed parts fall back to default strap use
      eff_sel  = programmed ? sel_mask  : 16'h0000;
      eff_off  = programmed ? off_mask  : 16'h0000;
      eff_addr = programmed ? addr_mask : 16'h0000;
      strap.main_i2c   = pins[`RSCS_PORT_SEL_PIN];
      strap.eeprom_off = |(pins & eff_off);
      strap.addr_bit   = top_pin(pins, eff_addr);
      if (eff_sel == 16'h0000) begin
         strap.sel_idx = {12'h000, pins[3:0]};
      end else begin
         strap.sel_idx = pack_pins(pins, eff_sel);
      end
   end

endmodule // rscs_strap_decode

// ===== verilog/rscs_top.sv
`timescale 1ns/1ns
`include "rscs_regs.svh"

module rscs_top
   import rscs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [15:0] gpio_in,
   input  wire logic        info_programmed,
   input  wire logic [15:0] info_sel_mask,
   input  wire logic [15:0] info_off_mask,
   input  wire logic [15:0] info_addr_mask,
   input  wire logic        otp_ack,
   input  wire logic        otp_csum_ok,
   input  rscs_cfg_t        otp_cfg,
   input  wire logic        ee_ack,
   input  wire logic        ee_found,
   input  rscs_cfg_t        ee_cfg,
   input  wire logic        pll_cal_done,
   input  wire logic        pll_locked_pin,
   input  wire logic        wr_port_en,
   input  wire logic        wr_main_i2c,
   input  wire logic        wr_addr_en,
   input  wire logic        wr_addr_bit,
   output logic             otp_req,
   output logic [15:0]      otp_idx,
   output logic             ee_req,
   output logic             reg_en,
   output logic             clk_en,
   output logic             pll_cal_req,
   output logic             init_done,
   output logic             main_i2c,
   output logic             aux_i2c,
   output logic             main_addr_bit_two,
   output logic             aux_addr_bit_two,
   output rscs_cfg_t        cfg
);

   logic [15:0] gpio_s1;
   logic [15:0] gpio_s2;
   logic        lock_s1;
   logic        lock_s2;
   logic [1:0]  cap_cnt;
   logic        cap_done;
   logic [15:0] pins_cap;
   logic        prog_cap;
   logic [15:0] sel_cap;
   logic [15:0] off_cap;
   logic [15:0] addr_cap;
   rscs_strap_t strap;
   rscs_state_t state;
   rscs_state_t next_state;
   logic [`RSCS_CNT_W-1:0] wait_cnt;
   logic        addr_bit;

   // Pad pull-ups: idle value of every strap is high
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gpio_s1 <= `RSCS_GPIO_IDLE;
         gpio_s2 <= `RSCS_GPIO_IDLE;
         lock_s1 <= 1'b0;
         lock_s2 <= 1'b0;
      end else begin
         gpio_s1 <= gpio_in;
         gpio_s2 <= gpio_s1;
         lock_s1 <= pll_locked_pin;
         lock_s2 <= lock_s1;
      end
   end

   // Samples straps once the synchroniser holds post-release levels
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cap_cnt  <= 2'h0;
         cap_done <= 1'b0;
         pins_cap <= `RSCS_GPIO_IDLE;
         prog_cap <= 1'b0;
         sel_cap  <= 16'h0000;
         off_cap  <= 16'h0000;
         addr_cap <= 16'h0000;
      end else if (!cap_done) begin
         if (cap_cnt == `RSCS_CAPTURE_CYCLE) begin
            cap_done <= 1'b1;
            pins_cap <= gpio_s2;
            prog_cap <= info_programmed;
            sel_cap  <= info_sel_mask;
            off_cap  <= info_off_mask;
            addr_cap <= info_addr_mask;
         end else begin
            cap_cnt <= cap_cnt + 2'h1;
         end
      end
   end

   rscs_strap_decode u_decode (
      .pins       (pins_cap),
      .programmed (prog_cap),
      .sel_mask   (sel_cap),
      .off_mask   (off_cap),
      .addr_mask  (addr_cap),
      .strap      (strap)
   );

   always_comb begin
      next_state = state;
      case (state)
         ST_CAPTURE:  if (cap_done) next_state = ST_OTP;
         ST_OTP:      next_state = prog_cap ? ST_OTP_WAIT : ST_EE;
         ST_OTP_WAIT: if (otp_ack) next_state = ST_EE;
         ST_EE:       next_state = strap.eeprom_off ? ST_REG : ST_EE_WAIT;
         ST_EE_WAIT:  if (ee_ack) next_state = ST_REG;
         ST_REG:      if (wait_cnt == '0) next_state = ST_CLK;
         ST_CLK:      if (wait_cnt == '0) next_state = ST_CAL;
         ST_CAL:      if (pll_cal_done) next_state = ST_LOCK;
         ST_LOCK:     if (lock_s2) next_state = ST_DONE;
         ST_DONE:     next_state = ST_DONE;
         default:     next_state = ST_CAPTURE;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_CAPTURE;
      end else begin
         state <= next_state;
      end
   end

   // Settle timer for regulators, then for internal clocks
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_cnt <= `RSCS_CNT_W'(`RSCS_REG_SETTLE_CYC - 1);
      end else if (state == ST_REG && wait_cnt == '0) begin
         wait_cnt <= `RSCS_CNT_W'(`RSCS_CLK_SETTLE_CYC - 1);
      end else if ((state == ST_REG || state == ST_CLK) && wait_cnt != '0) begin
         wait_cnt <= wait_cnt - `RSCS_CNT_W'(1);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         otp_req     <= 1'b0;
         otp_idx     <= 16'h0000;
         ee_req      <= 1'b0;
         reg_en      <= 1'b0;
         clk_en      <= 1'b0;
         pll_cal_req <= 1'b0;
         init_done   <= 1'b0;
      end else begin
         otp_req     <= (next_state == ST_OTP_WAIT) && !otp_ack;
         otp_idx     <= strap.sel_idx;
         ee_req      <= (next_state == ST_EE_WAIT) && !ee_ack;
         reg_en      <= reg_en || (next_state == ST_REG);
         clk_en      <= clk_en || (next_state == ST_CLK);
         pll_cal_req <= (next_state == ST_CAL);
         init_done   <= (next_state == ST_DONE);
      end
   end

   // Sources layered over reset defaults: OTP, then EEPROM
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg.out_clk_en <= `RSCS_OUT_EN_RESET;
         cfg.gpio_oe    <= `RSCS_GPIO_OE_RESET;
      end else if (state == ST_OTP_WAIT && otp_ack && otp_csum_ok) begin
         cfg <= otp_cfg;
      end else if (state == ST_EE_WAIT && ee_ack && ee_found) begin
         cfg <= ee_cfg;
      end
   end

   // Port roles and address bit: strap first, writes later
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         main_i2c <= 1'b0;
         aux_i2c  <= 1'b1;
         addr_bit <= 1'b0;
      end else if (state == ST_CAPTURE && cap_done) begin
         main_i2c <= strap.main_i2c;
         aux_i2c  <= !strap.main_i2c;
         addr_bit <= strap.addr_bit;
      end else begin
         if (wr_port_en) begin
            main_i2c <= wr_main_i2c;
            aux_i2c  <= !wr_main_i2c;
         end
         if (wr_addr_en) begin
            addr_bit <= wr_addr_bit;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         main_addr_bit_two <= 1'b0;
         aux_addr_bit_two  <= 1'b0;
      end else begin
         main_addr_bit_two <= main_i2c && addr_bit;
         aux_addr_bit_two  <= aux_i2c && addr_bit;
      end
   end

   property p_strap_hold;
      @(posedge clk) disable iff (!resetn)
      cap_done && $past(cap_done) |-> $stable(pins_cap) && $stable(sel_cap);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("strap capture changed");

   property p_capture_time;
      @(posedge clk) disable iff (!resetn)
      $rose(cap_done) |-> $past(cap_cnt) == 2'h2 && pins_cap == $past(gpio_s2);
   endproperty
   a_capture_time: assert property (p_capture_time) else $error("strap sample wrong");

   property p_roles_opposite;
      @(posedge clk) disable iff (!resetn)
      aux_i2c == !main_i2c;
   endproperty
   a_roles_opposite: assert property (p_roles_opposite) else $error("port roles clash");

   property p_spi_no_addr;
      @(posedge clk) disable iff (!resetn)
      !main_i2c ##1 !main_i2c |-> !main_addr_bit_two;
   endproperty
   a_spi_no_addr: assert property (p_spi_no_addr) else $error("address bit on spi port");

   property p_ee_skip;
      @(posedge clk) disable iff (!resetn)
      state == ST_EE && strap.eeprom_off |=> !ee_req [*2];
   endproperty
   a_ee_skip: assert property (p_ee_skip) else $error("eeprom read while disabled");

   property p_ee_search;
      @(posedge clk) disable iff (!resetn)
      state == ST_EE && !strap.eeprom_off |=> ee_req;
   endproperty
   a_ee_search: assert property (p_ee_search) else $error("eeprom search missing");

   property p_no_otp_unprog;
      @(posedge clk) disable iff (!resetn)
      state == ST_OTP && !prog_cap |=> !otp_req && state == ST_EE;
   endproperty
   a_no_otp_unprog: assert property (p_no_otp_unprog) else $error("otp load on blank part");

   property p_csum_fail;
      @(posedge clk) disable iff (!resetn)
      state == ST_OTP_WAIT && otp_ack && !otp_csum_ok |=> $stable(cfg);
   endproperty
   a_csum_fail: assert property (p_csum_fail) else $error("bad checksum loaded");

   property p_defaults;
      @(posedge clk) disable iff (!resetn)
      $rose(cap_done) |-> cfg.out_clk_en == 12'h000 && cfg.gpio_oe == 16'h0000;
   endproperty
   a_defaults: assert property (p_defaults) else $error("reset defaults not neutral");

   property p_order;
      @(posedge clk) disable iff (!resetn)
      $rose(pll_cal_req) |-> reg_en && clk_en && !otp_req && !ee_req;
   endproperty
   a_order: assert property (p_order) else $error("start-up order broken");

   property p_write_port;
      @(posedge clk) disable iff (!resetn)
      wr_port_en && state != ST_CAPTURE |=> main_i2c == $past(wr_main_i2c);
   endproperty
   a_write_port: assert property (p_write_port) else $error("port write lost");

   property p_idx;
      @(posedge clk) disable iff (!resetn)
      $rose(otp_req) |-> otp_idx == strap.sel_idx;
   endproperty
   a_idx: assert property (p_idx) else $error("otp index mismatch");

   property p_addr_i2c;
      @(posedge clk) disable iff (!resetn)
      main_i2c ##1 (main_i2c && $stable(addr_bit)) |-> main_addr_bit_two == addr_bit;
   endproperty
   a_addr_i2c: assert property (p_addr_i2c) else $error("address bit missing on i2c port");

   property p_otp_load;
      @(posedge clk) disable iff (!resetn)
      state == ST_OTP_WAIT && otp_ack && otp_csum_ok |=> cfg == $past(otp_cfg);
   endproperty
   a_otp_load: assert property (p_otp_load) else $error("otp data not loaded");

   property p_ee_load;
      @(posedge clk) disable iff (!resetn)
      state == ST_EE_WAIT && ee_ack && ee_found |=> cfg == $past(ee_cfg);
   endproperty
   a_ee_load: assert property (p_ee_load) else $error("eeprom data not loaded");

   property p_reg_time;
      @(posedge clk) disable iff (!resetn)
      $rose(clk_en) |-> $past(reg_en, `RSCS_REG_SETTLE_CYC) && !$past(reg_en, `RSCS_REG_SETTLE_CYC + 1);
   endproperty
   a_reg_time: assert property (p_reg_time) else $error("regulator settle time wrong");

   property p_clk_time;
      @(posedge clk) disable iff (!resetn)
      $rose(pll_cal_req) |-> $past(clk_en, `RSCS_CLK_SETTLE_CYC) && !$past(clk_en, `RSCS_CLK_SETTLE_CYC + 1);
   endproperty
   a_clk_time: assert property (p_clk_time) else $error("clock settle time wrong");

   property p_done;
      @(posedge clk) disable iff (!resetn)
      $rose(init_done) |-> $past(lock_s2) && !pll_cal_req;
   endproperty
   a_done: assert property (p_done) else $error("done before pll lock");

   property p_addr_none;
      @(posedge clk) disable iff (!resetn)
      $rose(cap_done) && (!prog_cap || addr_cap == 16'h0000) |=> !addr_bit;
   endproperty
   a_addr_none: assert property (p_addr_none) else $error("address bit set without pin");

   property p_sel_default;
      @(posedge clk) disable iff (!resetn)
      $rose(cap_done) && (!prog_cap || sel_cap == 16'h0000) |-> strap.sel_idx == {12'h000, pins_cap[3:0]};
   endproperty
   a_sel_default: assert property (p_sel_default) else $error("default index pins wrong");

   c_otp_load: cover property (@(posedge clk) disable iff (!resetn) otp_ack && otp_csum_ok);
   c_ee_load:  cover property (@(posedge clk) disable iff (!resetn) ee_ack && ee_found);
   c_ee_skip:  cover property (@(posedge clk) disable iff (!resetn) state == ST_EE && strap.eeprom_off);
   c_done:     cover property (@(posedge clk) disable iff (!resetn) $rose(init_done));

endmodule // rscs_top

// ===== bench/rscs_board_model.sv
`timescale 1ns/1ns

module rscs_board_model
   import rscs_pkg::*;
#(
   parameter rscs_cfg_t OTP_V = 28'h0a55a5a,
   parameter rscs_cfg_t EE_V  = 28'h3c3c3c3
)
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [15:0] drv,
   input  wire logic [15:0] val,
   input  wire logic [7:0]  lat,
   input  wire logic        csum,
   input  wire logic        found,
   input  wire logic        otp_req,
   input  wire logic        ee_req,
   input  wire logic        pll_cal_req,
   output logic [15:0]      gpio_in,
   output logic             otp_ack,
   output logic             otp_csum_ok,
   output rscs_cfg_t        otp_cfg,
   output logic             ee_ack,
   output logic             ee_found,
   output rscs_cfg_t        ee_cfg,
   output logic             pll_cal_done,
   output logic             pll_locked_pin
);
   logic [7:0] c_otp;
   logic [7:0] c_ee;
   logic [7:0] c_pll;

   // Undriven straps float high
   assign gpio_in = (drv & val) | ~drv;
   // Data lines are garbage outside the ack cycle
   assign otp_cfg     = otp_ack ? OTP_V : ~OTP_V;
   assign otp_csum_ok = otp_ack ? csum : ~csum;
   assign ee_cfg      = ee_ack ? EE_V : ~EE_V;
   assign ee_found    = ee_ack ? found : ~found;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         c_otp          <= 8'h00;
         c_ee           <= 8'h00;
         c_pll          <= 8'h00;
         otp_ack        <= 1'b0;
         ee_ack         <= 1'b0;
         pll_cal_done   <= 1'b0;
         pll_locked_pin <= 1'b0;
      end else begin
         c_otp        <= otp_req ? c_otp + 8'h01 : 8'h00;
         c_ee         <= ee_req ? c_ee + 8'h01 : 8'h00;
         c_pll        <= pll_cal_req ? c_pll + 8'h01 : 8'h00;
         otp_ack      <= otp_req && c_otp == lat && !otp_ack;
         ee_ack       <= ee_req && c_ee == lat && !ee_ack;
         pll_cal_done <= pll_cal_req && c_pll == lat && !pll_cal_done;
         if (pll_cal_done) begin
            pll_locked_pin <= 1'b1;
         end
      end
   end
endmodule // rscs_board_model

// ===== bench/rscs_top_bench.sv
`timescale 1ns/1ns

module rscs_top_bench
   import rscs_pkg::*;
;
   localparam rscs_cfg_t OTP_V = 28'h0a55a5a;
   localparam rscs_cfg_t EE_V  = 28'h3c3c3c3;

   logic clk, resetn, prog, csum, found;
   logic wr_port_en, wr_main_i2c, wr_addr_en, wr_addr_bit;
   logic [15:0] sel, off, adr, drv, val, gpio_in, otp_idx;
   logic [7:0] lat;
   logic otp_ack, otp_csum_ok, ee_ack, ee_found, pll_cal_done, pll_locked_pin;
   logic otp_req, ee_req, reg_en, clk_en, pll_cal_req, init_done;
   logic main_i2c, aux_i2c, main_addr_bit_two, aux_addr_bit_two;
   rscs_cfg_t otp_cfg, ee_cfg, cfg;
   int n_mismatch, total_checks;

   rscs_top u_dut (.clk(clk), .resetn(resetn), .gpio_in(gpio_in), .info_programmed(prog),
      .info_sel_mask(sel), .info_off_mask(off), .info_addr_mask(adr), .otp_ack(otp_ack),
      .otp_csum_ok(otp_csum_ok), .otp_cfg(otp_cfg), .ee_ack(ee_ack), .ee_found(ee_found),
      .ee_cfg(ee_cfg), .pll_cal_done(pll_cal_done), .pll_locked_pin(pll_locked_pin),
      .wr_port_en(wr_port_en), .wr_main_i2c(wr_main_i2c), .wr_addr_en(wr_addr_en),
      .wr_addr_bit(wr_addr_bit), .otp_req(otp_req), .otp_idx(otp_idx), .ee_req(ee_req),
      .reg_en(reg_en), .clk_en(clk_en), .pll_cal_req(pll_cal_req), .init_done(init_done),
      .main_i2c(main_i2c), .aux_i2c(aux_i2c), .main_addr_bit_two(main_addr_bit_two),
      .aux_addr_bit_two(aux_addr_bit_two), .cfg(cfg));

   rscs_board_model #(.OTP_V(OTP_V), .EE_V(EE_V)) u_board (.clk(clk), .resetn(resetn),
      .drv(drv), .val(val), .lat(lat), .csum(csum), .found(found), .otp_req(otp_req),
      .ee_req(ee_req), .pll_cal_req(pll_cal_req), .gpio_in(gpio_in), .otp_ack(otp_ack),
      .otp_csum_ok(otp_csum_ok), .otp_cfg(otp_cfg), .ee_ack(ee_ack), .ee_found(ee_found),
      .ee_cfg(ee_cfg), .pll_cal_done(pll_cal_done), .pll_locked_pin(pll_locked_pin));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // One full start-up with given straps and factory masks
   task automatic run(input logic p, input logic [15:0] sm, om, am, dv, vl, input logic ok, fd,
                      input logic xm, xma, xaa, input logic [15:0] xi, input logic xo, xe,
                      input rscs_cfg_t xc);
      logic so;
      logic se;
      int   i;
      @(posedge clk);
      resetn <= 1'b0;
      prog   <= p;
      sel    <= sm;
      off    <= om;
      adr    <= am;
      drv    <= dv;
      val    <= vl;
      csum   <= ok;
      found  <= fd;
      repeat (3) @(posedge clk);
      #1;
      check("cfg_in_reset", cfg, 28'h0);
      check("roles_in_reset", {main_i2c, aux_i2c}, 2'h1);
      repeat (17) @(posedge clk);
      resetn <= 1'b1;
      so = 1'b0;
      se = 1'b0;
      for (i = 0; i < 2000 && init_done !== 1'b1; i++) begin
         @(posedge clk);
         #1;
         so = so | (otp_req === 1'b1);
         se = se | (ee_req === 1'b1);
      end
      if (i == 2000) begin
         n_mismatch++;
         tally_and_finish();
      end
      check("main_i2c", main_i2c, xm);
      check("aux_i2c", aux_i2c, !xm);
      check("main_addr", main_addr_bit_two, xma);
      check("aux_addr", aux_addr_bit_two, xaa);
      check("otp_load", so, xo);
      check("ee_search", se, xe);
      if (xo) begin
         check("otp_idx", otp_idx, xi);
      end
      check("cfg", cfg, xc);
      check("reg_clk_en", {reg_en, clk_en}, 2'h3);
      check("cal_req_done", {pll_cal_req, init_done}, 2'h1);
      @(posedge clk);
      drv <= 16'hffff;
      val <= ~vl;
      repeat (5) @(posedge clk);
      #1;
      check("held_role", main_i2c, xm);
      check("held_addr", {main_addr_bit_two, aux_addr_bit_two}, {xma, xaa});
   endtask

   initial begin
      resetn      = 1'b0;
      prog        = 1'b0;
      sel         = 16'h0000;
      off         = 16'h0000;
      adr         = 16'h0000;
      drv         = 16'h0000;
      val         = 16'h0000;
      lat         = 8'h00;
      csum        = 1'b1;
      found       = 1'b1;
      wr_port_en  = 1'b0;
      wr_main_i2c = 1'b0;
      wr_addr_en  = 1'b0;
      wr_addr_bit = 1'b0;
      run(1'b0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1, 1, 1, 0, 0, 16'h0, 0, 1, EE_V);
      run(1'b1, 16'h0, 16'h0, 16'h0400, 16'h060f, 16'h0405, 1, 0, 0, 0, 1, 16'h0005, 1, 1, OTP_V);
      lat <= 8'h14;
      run(1'b1, 16'h0234, 16'h0082, 16'h0021, 16'hffff, 16'h02a4, 0, 1, 1, 1, 0, 16'h000d, 1, 0,
          28'h0);
      run(1'b1, 16'h0042, 16'h0, 16'h0, 16'h0, 16'h0, 1, 1, 1, 0, 0, 16'h0003, 1, 1, EE_V);
      run(1'b1, 16'h003f, 16'h0100, 16'h0001, 16'h003f, 16'h0029, 1, 0, 1, 1, 0, 16'h0029, 1, 0,
          OTP_V);
      lat <= 8'h00;
      run(1'b1, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 1, 0, 1, 0, 0, 16'h000f, 1, 1, OTP_V);
      // Later writes replace strapped role and address bit
      @(posedge clk);
      wr_port_en  <= 1'b1;
      wr_main_i2c <= 1'b0;
      @(posedge clk);
      wr_port_en  <= 1'b0;
      wr_addr_en  <= 1'b1;
      wr_addr_bit <= 1'b1;
      @(posedge clk);
      wr_addr_en <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check("wr_role", {main_i2c, aux_i2c}, 2'h1);
      check("wr_addr", {main_addr_bit_two, aux_addr_bit_two}, 2'h1);
      tally_and_finish();
   end
endmodule // rscs_top_bench
